/* File: verilog/mdm_pkg.sv */
/*
 * shared constants and types of the management serial link master:
 * register offsets, field positions, reset values, frame layout, states.
 * assumes a single 100 MHz clock domain and 12-bit register addresses.
 */
package mdm_pkg;

   // ==========================================================
   // register offsets
   localparam logic [11:0] OFS_LINK_SETUP       = 12'h500;
   localparam logic [11:0] OFS_TRANSFER_CONTROL = 12'h504;
   localparam logic [11:0] OFS_WRITE_PAYLOAD    = 12'h508;
   localparam logic [11:0] OFS_READ_RESULT      = 12'h50c;
   localparam logic [11:0] OFS_IRQ_RAW_STATUS   = 12'h600;
   localparam logic [11:0] OFS_IRQ_PENDING      = 12'h610;
   localparam logic [11:0] OFS_IRQ_ENABLE       = 12'h620;
   localparam logic [11:0] OFS_IRQ_CLEAR        = 12'h630;

   // ==========================================================
   // field positions
   localparam int BIT_LINK_EN   = 6;
   localparam int DIV_HI        = 5;
   localparam int PHY_HI        = 28;
   localparam int PHY_LO        = 24;
   localparam int REGA_HI       = 20;
   localparam int REGA_LO       = 16;
   localparam int OP_HI         = 15;
   localparam int OP_LO         = 14;
   localparam int BIT_START     = 11;
   localparam int BIT_READY     = 7;
   localparam int BIT_RD_READY  = 16;
   localparam int BIT_XFER_DONE = 0;

   // ==========================================================
   // reset values
   localparam logic [5:0]  RST_DIVISOR = 6'h00;
   localparam logic [4:0]  RST_ADDR5   = 5'h00;
   localparam logic [1:0]  RST_OPCODE  = 2'h0;
   localparam logic [15:0] RST_DATA16  = 16'h0000;
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;

   // ==========================================================
   // frame layout
   localparam logic [1:0]  OP_WRITE     = 2'b01;
   localparam logic [1:0]  OP_READ      = 2'b10;
   localparam logic [31:0] FRM_PREAMBLE = 32'hffff_ffff;
   localparam logic [1:0]  FRM_START    = 2'b01;
   localparam logic [1:0]  FRM_TA_WRITE = 2'b10;
   localparam logic [5:0]  CNT_TA_FIRST = 6'h2e;
   localparam logic [5:0]  CNT_RD_FIRST = 6'h30;
   localparam logic [5:0]  CNT_LAST     = 6'h3f;
   localparam logic [5:0]  CNT_ZERO     = 6'h00;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_LEAD  = 3'b010,
      ST_SHIFT = 3'b100
   } mdm_fsm_t;

   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [31:0] wdata;
   } mdm_reg_req_t;

endpackage

/* File: verilog/mdm_sync.sv */
/*
 * two-flop synchroniser for the serial data pin.
 * assumes the pin level is asynchronous to clk.
 */
`timescale 1ns/1ns
module mdm_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
   } mdm_sync_state_t;

   mdm_sync_state_t s_r;
   mdm_sync_state_t s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = async_in;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_out = s_r.s2;
endmodule

/* File: verilog/mdm_clkdiv.sv */
/*
 * management clock divider: mdc period is 2*(divisor+1) clk cycles.
 * assumes run is from clk logic; mdc rests low while run is low.
 */
`timescale 1ns/1ns
module mdm_clkdiv (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic [5:0] divisor,
   output logic            mdc,
   output logic            rise_tick,
   output logic            fall_tick
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       mdc;
      logic       rise;
      logic       fall;
   } mdm_div_state_t;

   mdm_div_state_t s_r;
   mdm_div_state_t s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.rise = 1'b0;
      s_nxt.fall = 1'b0;
      if (!run) begin
         s_nxt.cnt = mdm_pkg::CNT_ZERO;
         s_nxt.mdc = 1'b0;
      end else if (s_r.cnt >= divisor) begin
         s_nxt.cnt  = mdm_pkg::CNT_ZERO;
         s_nxt.mdc  = ~s_r.mdc;
         s_nxt.rise = ~s_r.mdc;
         s_nxt.fall = s_r.mdc;
      end else begin
         s_nxt.cnt = s_r.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mdc       = s_r.mdc;
   assign rise_tick = s_r.rise;
   assign fall_tick = s_r.fall;
endmodule

/* File: verilog/mdm_top.sv */
/*
 * register-mapped master for the management serial link with a
 * transfer-complete interrupt controller.
 * assumes a register port on clk where each request is one-cycle valid,
 * and external phy devices on the mdc/mdio pins.
 */
//
// Behaviour
// RQ1 - link reached only through mapped registers
// RQ2 - link active only while enable bit set
// RQ3 - enable write ignored unless divisor nonzero
// RQ4 - phy address from control bits 28:24
// RQ5 - register address from control bits 20:16
// RQ6 - opcode 01 writes, 10 reads
// RQ7 - start bit 11 begins a transfer
// RQ8 - ready bit 7 shows enabled and idle
// RQ9 - write payload bits 15:0 sent
// RQ10 - ready mirrored into read result bit 16
// RQ11 - read result in bits 15:0
// RQ12 - raw status register at 0x600
// RQ13 - pending is status and enable
// RQ14 - enable register at 0x620
// RQ15 - writing one to 0x630 clears
// RQ16 - bit 0 is transfer complete
// RQ17 - status sets with ready returning high
// RQ18 - clause 22 frame, divided clock
`timescale 1ns/1ns
module mdm_top (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  reg_req_valid,
   input  wire mdm_pkg::mdm_reg_req_t reg_req,
   output logic                       reg_ack,
   output logic [31:0]                reg_rdata,
   output logic                       mdc,
   input  wire logic                  mdio_in,
   output logic                       mdio_out,
   output logic                       mdio_oe,
   output logic                       irq
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [5:0]        divisor;
      logic              link_en;
      logic [4:0]        target_phy_addr;
      logic [4:0]        target_reg_addr;
      logic [1:0]        transfer_opcode;
      logic [15:0]       write_payload;
      logic [15:0]       read_result;
      logic              ready;
      logic              irq_raw_status;
      logic              irq_enable_bits;
      logic              irq;
      mdm_pkg::mdm_fsm_t fsm;
      logic [5:0]        bit_cnt;
      logic [63:0]       frame;
      logic              is_read;
      logic              mdio_out;
      logic              mdio_oe;
      logic              ack;
      logic [31:0]       rdata;
   } mdm_top_state_t;

   mdm_top_state_t s_r;
   mdm_top_state_t s_nxt;

   logic mdio_sync;
   logic rise_tick;
   logic fall_tick;
   logic wr_setup;
   logic wr_ctrl;
   logic wr_payload;
   logic wr_ien;
   logic wr_clear;
   logic start_req;
   logic xfer_done;
   logic [5:0] new_div;

   // ==========================================================
   // helpers
   function automatic logic addr_hit(
      input logic [11:0] addr,
      input logic [11:0] ofs
   );
      addr_hit = (addr == ofs);
   endfunction

   // preamble, start, opcode, phy, register, turnaround, data
   function automatic logic [63:0] build_frame(
      input logic [1:0]  op,
      input logic [4:0]  phy,
      input logic [4:0]  rega,
      input logic [15:0] data
   );
      logic [1:0] ta;
      ta = (op == mdm_pkg::OP_READ) ? 2'b11 : mdm_pkg::FRM_TA_WRITE;
      build_frame = {mdm_pkg::FRM_PREAMBLE, mdm_pkg::FRM_START, op, phy, rega, ta, data};
   endfunction

   // ==========================================================
   // submodules
   mdm_sync u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (mdio_in),
      .sync_out (mdio_sync)
   );

   // divider only runs while the link is enabled, so mdc rests low
   mdm_clkdiv u_div (
      .clk       (clk),
      .reset_n   (reset_n),
      .run       (s_r.link_en), // RQ2 RQ18
      .divisor   (s_r.divisor),
      .mdc       (mdc),
      .rise_tick (rise_tick),
      .fall_tick (fall_tick)
   );

   // ==========================================================
   // register decode
   always_comb begin
      wr_setup   = 1'b0;
      wr_ctrl    = 1'b0;
      wr_payload = 1'b0;
      wr_ien     = 1'b0;
      wr_clear   = 1'b0;
      if (reg_req_valid && reg_req.we) begin
         if (addr_hit(reg_req.addr, mdm_pkg::OFS_LINK_SETUP)) begin // RQ1
            wr_setup = 1'b1;
         end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_TRANSFER_CONTROL)) begin
            wr_ctrl = 1'b1;
         end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_WRITE_PAYLOAD)) begin
            wr_payload = 1'b1;
         end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_IRQ_ENABLE)) begin
            wr_ien = 1'b1;
         end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_IRQ_CLEAR)) begin
            wr_clear = 1'b1;
         end
      end
   end

   assign new_div = reg_req.wdata[mdm_pkg::DIV_HI:0];

   // start taken only when ready and the opcode names a transfer
   assign start_req = wr_ctrl
                    && reg_req.wdata[mdm_pkg::BIT_START] // RQ7
                    && s_r.ready
                    && ((reg_req.wdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO] == mdm_pkg::OP_WRITE)
                     || (reg_req.wdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO] == mdm_pkg::OP_READ));

   // the last bit is sampled on the final rising edge
   assign xfer_done = (s_r.fsm == mdm_pkg::ST_SHIFT) && rise_tick
                    && (s_r.bit_cnt == mdm_pkg::CNT_LAST);

   // ==========================================================
   // next state
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = 1'b0;

      // setup word
      if (wr_setup) begin
         s_nxt.divisor = new_div;
         // divisor is written in the same access, so its new value counts
         if (new_div != mdm_pkg::RST_DIVISOR) begin
            s_nxt.link_en = reg_req.wdata[mdm_pkg::BIT_LINK_EN]; // RQ3
         end
      end

      // control word fields
      if (wr_ctrl) begin
         s_nxt.target_phy_addr = reg_req.wdata[mdm_pkg::PHY_HI:mdm_pkg::PHY_LO]; // RQ4
         s_nxt.target_reg_addr = reg_req.wdata[mdm_pkg::REGA_HI:mdm_pkg::REGA_LO]; // RQ5
         s_nxt.transfer_opcode = reg_req.wdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO]; // RQ6
      end

      if (wr_payload) begin
         s_nxt.write_payload = reg_req.wdata[15:0]; // RQ9
      end

      if (wr_ien) begin
         s_nxt.irq_enable_bits = reg_req.wdata[mdm_pkg::BIT_XFER_DONE]; // RQ14
      end

      // ------------------------------------------------------
      // frame engine
      case (s_r.fsm)
         mdm_pkg::ST_IDLE: begin
            s_nxt.mdio_oe = 1'b0;
            if (start_req) begin
               s_nxt.frame = build_frame(
                  reg_req.wdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO], // RQ6
                  reg_req.wdata[mdm_pkg::PHY_HI:mdm_pkg::PHY_LO],
                  reg_req.wdata[mdm_pkg::REGA_HI:mdm_pkg::REGA_LO],
                  s_r.write_payload); // RQ9 RQ18
               s_nxt.is_read  = (reg_req.wdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO]
                                 == mdm_pkg::OP_READ);
               s_nxt.bit_cnt  = mdm_pkg::CNT_ZERO;
               s_nxt.mdio_out = 1'b1;
               s_nxt.mdio_oe  = 1'b1;
               s_nxt.fsm      = mdm_pkg::ST_LEAD;
            end
         end
         mdm_pkg::ST_LEAD: begin
            // mdc may be high at start; wait for a rising edge first
            if (rise_tick) begin
               s_nxt.fsm = mdm_pkg::ST_SHIFT;
            end
         end
         mdm_pkg::ST_SHIFT: begin
            if (rise_tick) begin
               if (s_r.is_read && (s_r.bit_cnt >= mdm_pkg::CNT_RD_FIRST)) begin
                  s_nxt.read_result = {s_r.read_result[14:0], mdio_sync}; // RQ11
               end
               if (xfer_done) begin
                  s_nxt.fsm     = mdm_pkg::ST_IDLE;
                  s_nxt.mdio_oe = 1'b0;
               end
            end else if (fall_tick) begin
               s_nxt.bit_cnt  = s_r.bit_cnt + 6'h01;
               s_nxt.frame    = {s_r.frame[62:0], 1'b0};
               s_nxt.mdio_out = s_r.frame[62];
               // release the line from the turnaround of a read
               s_nxt.mdio_oe  = !(s_r.is_read
                                  && ((s_r.bit_cnt + 6'h01) >= mdm_pkg::CNT_TA_FIRST));
            end
         end
         default: begin
            s_nxt.fsm     = mdm_pkg::ST_IDLE;
            s_nxt.mdio_oe = 1'b0;
         end
      endcase

      // disabling mid-frame abandons it without a completion event
      if (!s_nxt.link_en) begin
         s_nxt.fsm      = mdm_pkg::ST_IDLE; // RQ2
         s_nxt.mdio_oe  = 1'b0;
         s_nxt.mdio_out = 1'b0;
      end

      s_nxt.ready = s_nxt.link_en && (s_nxt.fsm == mdm_pkg::ST_IDLE); // RQ8

      // ------------------------------------------------------
      // interrupt controller, set wins over clear
      if (wr_clear && reg_req.wdata[mdm_pkg::BIT_XFER_DONE]) begin
         s_nxt.irq_raw_status = 1'b0; // RQ15
      end
      if (xfer_done && s_nxt.link_en) begin
         s_nxt.irq_raw_status = 1'b1; // RQ12 RQ16 RQ17
      end
      s_nxt.irq = s_nxt.irq_raw_status && s_nxt.irq_enable_bits; // RQ13

      // ------------------------------------------------------
      // read path, one cycle after the request
      if (reg_req_valid) begin
         s_nxt.ack   = 1'b1;
         s_nxt.rdata = mdm_pkg::RST_WORD;
         if (!reg_req.we) begin
            if (addr_hit(reg_req.addr, mdm_pkg::OFS_LINK_SETUP)) begin
               s_nxt.rdata[mdm_pkg::BIT_LINK_EN] = s_r.link_en;
               s_nxt.rdata[mdm_pkg::DIV_HI:0]    = s_r.divisor;
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_TRANSFER_CONTROL)) begin
               s_nxt.rdata[mdm_pkg::PHY_HI:mdm_pkg::PHY_LO]   = s_r.target_phy_addr;
               s_nxt.rdata[mdm_pkg::REGA_HI:mdm_pkg::REGA_LO] = s_r.target_reg_addr;
               s_nxt.rdata[mdm_pkg::OP_HI:mdm_pkg::OP_LO]     = s_r.transfer_opcode;
               s_nxt.rdata[mdm_pkg::BIT_READY]                = s_r.ready; // RQ8
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_WRITE_PAYLOAD)) begin
               s_nxt.rdata[15:0] = s_r.write_payload;
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_READ_RESULT)) begin
               s_nxt.rdata[mdm_pkg::BIT_RD_READY] = s_r.ready; // RQ10
               s_nxt.rdata[15:0]                  = s_r.read_result; // RQ11
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_IRQ_RAW_STATUS)) begin
               s_nxt.rdata[mdm_pkg::BIT_XFER_DONE] = s_r.irq_raw_status; // RQ12
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_IRQ_PENDING)) begin
               s_nxt.rdata[mdm_pkg::BIT_XFER_DONE] = s_r.irq; // RQ13
            end else if (addr_hit(reg_req.addr, mdm_pkg::OFS_IRQ_ENABLE)) begin
               s_nxt.rdata[mdm_pkg::BIT_XFER_DONE] = s_r.irq_enable_bits;
            end
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r.divisor         <= mdm_pkg::RST_DIVISOR;
         s_r.link_en         <= 1'b0;
         s_r.target_phy_addr <= mdm_pkg::RST_ADDR5;
         s_r.target_reg_addr <= mdm_pkg::RST_ADDR5;
         s_r.transfer_opcode <= mdm_pkg::RST_OPCODE;
         s_r.write_payload   <= mdm_pkg::RST_DATA16;
         s_r.read_result     <= mdm_pkg::RST_DATA16;
         s_r.ready           <= 1'b0;
         s_r.irq_raw_status  <= 1'b0;
         s_r.irq_enable_bits <= 1'b0;
         s_r.irq             <= 1'b0;
         s_r.fsm             <= mdm_pkg::ST_IDLE;
         s_r.bit_cnt         <= mdm_pkg::CNT_ZERO;
         s_r.frame           <= '0;
         s_r.is_read         <= 1'b0;
         s_r.mdio_out        <= 1'b0;
         s_r.mdio_oe         <= 1'b0;
         s_r.ack             <= 1'b0;
         s_r.rdata           <= mdm_pkg::RST_WORD;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign reg_ack   = s_r.ack;
   assign reg_rdata = s_r.rdata;
   assign mdio_out  = s_r.mdio_out;
   assign mdio_oe   = s_r.mdio_oe;
   assign irq       = s_r.irq;

endmodule

/* File: verification/mdm_top_props.sv */
/* port checker for mdm_top.
   assumes one clk domain and the bind at the foot of this file. */
`timescale 1ns/1ns
// =====
// checker
module mdm_chk (
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic                  reg_req_valid,
   input wire mdm_pkg::mdm_reg_req_t reg_req,
   input wire logic                  reg_ack,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  mdc,
   input wire logic                  mdio_out,
   input wire logic                  mdio_oe,
   input wire logic                  irq
);
   logic       en_r;
   logic [5:0] div_r;
   logic       ien_r;
   logic       rd;
   logic       wr;
   assign rd = reg_req_valid && !reg_req.we;
   assign wr = reg_req_valid && reg_req.we;
   // shadow of the enable bits, kept from the writes seen on the port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         en_r  <= 1'b0;
         div_r <= 6'h00;
         ien_r <= 1'b0;
      end else if (wr && reg_req.addr == 12'h500) begin
         div_r <= reg_req.wdata[5:0];
         if (reg_req.wdata[5:0] != 6'h00) begin
            en_r <= reg_req.wdata[6];
         end
      end else if (wr && reg_req.addr == 12'h620) begin
         ien_r <= reg_req.wdata[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_ACK: assert property (reg_req_valid |=> reg_ack)
      else $error("request not acked one cycle later");
   AST_NO_ACK: assert property (!reg_req_valid |=> !reg_ack)
      else $error("ack without a request");
   AST_WR_ZERO: assert property (wr |=> reg_rdata == 32'h0000_0000)
      else $error("write answered with nonzero data");
   AST_SETUP_RD: assert property (rd && reg_req.addr == 12'h500 |=>
      reg_rdata == {25'h0, $past(en_r), $past(div_r)})
      else $error("setup readback wrong");
   AST_CTRL_RD: assert property (rd && reg_req.addr == 12'h504 |=>
      (reg_rdata & 32'he0e0_3f7f) == 32'h0000_0000)
      else $error("control start or reserved bits read nonzero");
   AST_RES_RD: assert property (rd && reg_req.addr == 12'h50c |=>
      reg_rdata[31:17] == 15'h0)
      else $error("read result reserved bits nonzero");
   AST_IRQ_RSV: assert property (rd && reg_req.addr[11:8] == 4'h6 |=>
      reg_rdata[31:1] == 31'h0)
      else $error("interrupt register reserved bits nonzero");
   AST_LINK_OFF: assert property (!en_r [*3] |-> !mdc && !mdio_oe)
      else $error("link active while disabled");
   AST_IRQ_MASK: assert property (!ien_r [*3] |-> !irq)
      else $error("irq while source disabled");
   AST_OUT_EDGE: assert property (mdio_oe && $past(mdio_oe) &&
      mdio_out != $past(mdio_out) |-> $past(mdc, 2) && !$past(mdc))
      else $error("data changed away from a falling mdc");
endmodule

bind mdm_top mdm_chk u_chk (
   .clk(clk), .reset_n(reset_n), .reg_req_valid(reg_req_valid),
   .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
   .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq)
);

/* File: verification/mdm_phy_model.sv */
/* behavioural phy on the management link.
   assumes mdc from the master and a pull-up on the data line. */
`timescale 1ns/1ns
// =====
// phy model
module mdm_phy_model (
   input  wire logic        reset_n,
   input  wire logic        mdc,
   input  wire logic        mdio_out,
   input  wire logic        mdio_oe,
   input  wire logic [15:0] rd_value,
   output logic             line,
   output logic [29:0]      frm,
   output logic [7:0]       nfr
);
   logic [33:0] sr;
   logic [1:0]  op_r;
   logic        phy_oe;
   logic        phy_out;
   int          pos;
   // released line floats high through the pull-up
   assign line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
   always @(posedge mdc or negedge reset_n) begin
      if (!reset_n) begin
         sr = '0;
         pos = -1;
         frm = '0;
         nfr = '0;
         op_r = 2'h0;
      end else begin
         sr = {sr[32:0], line};
         if (pos >= 0) begin
            frm = {frm[28:0], line};
            pos = pos + 1;
         end
         if (pos == 2) begin
            op_r = frm[1:0];
         end
         if (pos == 30) begin
            nfr = nfr + 8'h01;
            pos = -1;
         end else if (pos < 0 && sr == {32'hffff_ffff, 2'b01}) begin
            pos = 0;
         end
      end
   end
   // drive on falling mdc so the master sees a settled level at the rise
   always @(negedge mdc or negedge reset_n) begin
      if (!reset_n) begin
         phy_oe = 1'b0;
         phy_out = 1'b0;
      end else if (pos >= 13 && op_r == 2'b10) begin
         phy_oe = 1'b1;
         phy_out = (pos == 13) ? 1'b0 : rd_value[29 - pos];
      end else begin
         phy_oe = 1'b0;
      end
   end
endmodule

/* File: verification/tb.sv */
/* self-checking bench for mdm_top with a phy model.
   assumes a 100 MHz clk and an mdc of 160 ns (divisor 7). */
`timescale 1ns/1ns
module tb;
   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  reg_req_valid = 1'b0;
   mdm_pkg::mdm_reg_req_t reg_req = '0;
   logic                  reg_ack, mdc, mdio_out, mdio_oe, irq, line;
   logic [31:0]           reg_rdata;
   logic [29:0]           frm;
   logic [7:0]            nfr, nfr0;
   logic [15:0]           rd_value = 16'h0000;
   logic [15:0]           wd, last_rd;
   logic [4:0]            phy, rega;
   logic [1:0]            op;
   logic [31:0]           r = 32'h0000_0057;
   logic [11:0]           ofs [8] = '{12'h500, 12'h504, 12'h508, 12'h50c,
                                      12'h600, 12'h610, 12'h620, 12'h7fc};
   logic                  ien;
   int                    failures = 0;
   int                    comparisons = 0;
   int                    cycles = 0;

   mdm_top dut (.clk(clk), .reset_n(reset_n), .reg_req_valid(reg_req_valid),
      .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .mdc(mdc),
      .mdio_in(line), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq));
   mdm_phy_model phy_m (.reset_n(reset_n), .mdc(mdc), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .rd_value(rd_value), .line(line), .frm(frm), .nfr(nfr));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         complete_run();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [31:0] cexp(input logic rdy);
      return {3'h0, phy, 3'h0, rega, op, 6'h00, rdy, 7'h00};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one access: valid for one cycle, ack checked the cycle after
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      reg_req_valid = 1'b1;
      reg_req = '{we: w, addr: a, wdata: d};
      @(negedge clk);
      reg_req_valid = 1'b0;
      chk({31'h0, reg_ack}, 32'h0000_0001);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0000_0000);
      chk(reg_rdata, exp);
   endtask

   task automatic wait_rdy();
      for (int k = 0; k < 600; k++) begin
         acc(1'b0, 12'h504, 32'h0000_0000);
         if (reg_rdata[7] === 1'b1) begin
            break;
         end
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      last_rd = 16'h0000;
      ien = 1'b0;
      phy = 5'h00;
      rega = 5'h00;
      op = 2'h0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      foreach (ofs[i]) rd_chk(ofs[i], 32'h0000_0000);
      acc(1'b1, 12'h500, 32'h0000_0040);
      rd_chk(12'h500, 32'h0000_0000);
      acc(1'b1, 12'h500, 32'hffff_ff47);
      rd_chk(12'h500, 32'h0000_0047);
      rd_chk(12'h504, 32'h0000_0080);
      rd_chk(12'h50c, 32'h0001_0000);
      for (int i = 0; i < 4; i++) begin
         r = xs(r);
         wd = r[15:0];
         phy = r[20:16];
         rega = r[25:21];
         r = xs(r);
         rd_value = r[15:0];
         op = i[0] ? 2'b10 : 2'b01;
         if (i == 2) begin
            ien = 1'b1;
            acc(1'b1, 12'h620, 32'hffff_ffff);
            rd_chk(12'h620, 32'h0000_0001);
         end
         acc(1'b1, 12'h508, {16'hffff, wd});
         rd_chk(12'h508, {16'h0000, wd});
         acc(1'b1, 12'h504, {3'h7, phy, 3'h7, rega, op, 3'h7, 3'h7, 8'hff});
         rd_chk(12'h504, cexp(1'b0));
         wait_rdy();
         rd_chk(12'h504, cexp(1'b1));
         chk({2'h0, frm}, {2'h0, op, phy, rega, 2'b10, op[0] ? wd : rd_value});
         if (op == 2'b10) begin
            last_rd = rd_value;
         end
         rd_chk(12'h50c, {15'h0, 1'b1, last_rd});
         rd_chk(12'h600, 32'h0000_0001);
         rd_chk(12'h610, {31'h0, ien});
         chk({31'h0, irq}, {31'h0, ien});
         acc(1'b1, 12'h630, 32'hffff_ffff);
         rd_chk(12'h600, 32'h0000_0000);
         chk({31'h0, irq}, 32'h0000_0000);
      end
      // opcodes 00 and 11 are stored but start nothing
      nfr0 = nfr;
      for (int c = 0; c < 4; c += 3) begin
         op = c[1:0];
         acc(1'b1, 12'h504, {3'h0, phy, 3'h0, rega, op, 2'h0, 4'h8, 8'h00});
         repeat (200) @(negedge clk);
         rd_chk(12'h504, cexp(1'b1));
      end
      chk({24'h0, nfr}, {24'h0, nfr0});
      // abort: clearing enable mid-frame
      op = 2'b01;
      acc(1'b1, 12'h504, {3'h0, phy, 3'h0, rega, op, 2'h0, 4'h8, 8'h00});
      repeat (300) @(negedge clk);
      acc(1'b1, 12'h500, 32'h0000_0007);
      // mdc is released one cycle after the enable register drops
      @(negedge clk);
      chk({29'h0, mdc, mdio_oe, mdio_out}, 32'h0000_0000);
      rd_chk(12'h504, cexp(1'b0));
      rd_chk(12'h600, 32'h0000_0000);
      rd_chk(12'h50c, {16'h0000, last_rd});
      complete_run();
   end
endmodule
